// >>> hw/phy_aux_pkg.sv
package phy_aux_pkg;
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned RESET_MIN_US = 1000;
  // strictly more than 1 ms: one extra cycle on top of the rounded-down count
  localparam int unsigned RESET_CYCLES = (CLOCK_HZ / 1_000_000) * RESET_MIN_US + 1;
  localparam int unsigned BLINK_SLOW_HZ = 10;
  localparam int unsigned BLINK_FAST_HZ = 20;
  // half period of each blink, rounded down
  localparam int unsigned SLOW_HALF_CYCLES = CLOCK_HZ / (2 * BLINK_SLOW_HZ);
  localparam int unsigned FAST_HALF_CYCLES = CLOCK_HZ / (2 * BLINK_FAST_HZ);
  localparam int unsigned CNT_W = 24;
  localparam int unsigned LED_COUNT = 5;
  localparam int unsigned STRAP_SPEED_LOW_BIT = 7;
  localparam int unsigned STRAP_ACTIVITY_BIT = 6;
  localparam int unsigned STRAP_LINK_BIT = 5;
  localparam int unsigned STRAP_DUPLEX_BIT = 4;
  localparam int unsigned STRAP_SPEED_HIGH_BIT = 3;
  localparam int unsigned CODING_BYPASS_BIT = 1;
  localparam int unsigned CTRL_LOOPBACK_BIT = 14;
  localparam int unsigned CTRL_AUTONEG_BIT = 12;
  localparam int unsigned CTRL_POWER_DOWN_BIT = 11;
  localparam logic [15:0] REG_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_POWER_UP,
    ST_RESETTING,
    ST_RUNNING
  } reset_state_t;
endpackage

// >>> hw/blink_divider.sv
`timescale 1ns/1ps
`default_nettype none
// free-running square wave; half period given in clock cycles
module blink_divider #(
  parameter int unsigned HALF_CYCLES = 2
) (
  input wire logic clock,
  input wire logic rst,
  output logic wave
);
  import phy_aux_pkg::*;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYCLES - 1);
  logic [CNT_W-1:0] count;
  wire at_last = (count == LAST);
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
      wave <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + 1'b1;
      if (at_last) begin
        wave <= ~wave;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a vector of pins
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> hw/phy_led_strap_reset_ctrl.sv
// Summary of operation
// - speed_low_led steady on at 10 Mb/s only
// - LED pin straps latched into bits 7..3
// - activity_led blinks 10 Hz during activity
// - link_led on for good link, blinks on activity
// - duplex_collision_led on in full duplex
// - half duplex collision blinks duplex LED 20 Hz
// - speed_high_led steady on at 100 Mb/s
// - autoneg on: straps select advertised modes
// - autoneg off: config_strap_a sets coding bypass bit
// - autoneg on: config_strap_b feeds advertisement select
// - autoneg off: config_strap_b sets loopback bit
// - power-up reset lasts more than 1 ms
// - reset_done low until reset completes
// - power-down is pin OR control bit
// - power-down tristates LEDs and transmit, isolates MII
`timescale 1ns/1ps
`default_nettype none
module phy_led_strap_reset_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic power_down_pin,
  input wire logic config_strap_a,
  input wire logic config_strap_b,
  input wire logic [phy_aux_pkg::LED_COUNT-1:0] led_in,
  output logic [phy_aux_pkg::LED_COUNT-1:0] led_out,
  output logic [phy_aux_pkg::LED_COUNT-1:0] led_oe,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic activity,
  input wire logic collision,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reset_done,
  output logic power_down,
  output logic tx_tristate,
  output logic mii_isolate,
  output logic [1:0] advert_select,
  output logic advert_valid
);
  import phy_aux_pkg::*;

  // LED vector order: [4]=speed_low [3]=activity [2]=link [1]=duplex [0]=speed_high
  localparam int unsigned LED_SPEED_LOW = 4;
  localparam int unsigned LED_ACTIVITY = 3;
  localparam int unsigned LED_LINK = 2;
  localparam int unsigned LED_DUPLEX = 1;
  localparam int unsigned LED_SPEED_HIGH = 0;
  localparam logic [3:0] ADDR_BASIC = 4'h0;
  localparam logic [3:0] ADDR_CODING = 4'h1;
  localparam logic [3:0] ADDR_STRAP = 4'h2;
  localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYCLES - 1);

  // pins from outside the clock domain
  logic [LED_COUNT+3:0] pins_sync;
  pin_sync #(
    .WIDTH(LED_COUNT + 4)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({led_in, reset_n_pin, power_down_pin, config_strap_a, config_strap_b}),
    .sync_out(pins_sync)
  );
  wire [LED_COUNT-1:0] led_in_s = pins_sync[LED_COUNT+3:4];
  wire reset_n_s = pins_sync[3];
  wire power_down_s = pins_sync[2];
  wire strap_a_s = pins_sync[1];
  wire strap_b_s = pins_sync[0];

  logic blink_slow;
  logic blink_fast;
  blink_divider #(
    .HALF_CYCLES(SLOW_HALF_CYCLES)
  ) u_slow (
    .clock(clock),
    .rst(rst),
    .wave(blink_slow)
  );
  blink_divider #(
    .HALF_CYCLES(FAST_HALF_CYCLES)
  ) u_fast (
    .clock(clock),
    .rst(rst),
    .wave(blink_fast)
  );

  // reset sequencer: rst is power-up, reset pin low restarts it
  reset_state_t state;
  reset_state_t next_state;
  logic [CNT_W-1:0] reset_count;
  logic [CNT_W-1:0] next_reset_count;
  logic [15:0] basic_control_register;
  logic [15:0] coding_control_register;
  logic [15:0] led_strap_register;

  wire count_done = (reset_count == RESET_LAST);
  wire in_reset = (state != ST_RUNNING);
  wire autoneg_on = basic_control_register[CTRL_AUTONEG_BIT];

  always_comb begin
    next_state = state;
    next_reset_count = reset_count;
    case (state)
      ST_POWER_UP: begin
        // pin level ignored: power-up always resets
        next_reset_count = '0;
        next_state = ST_RESETTING;
      end
      ST_RESETTING: begin
        next_reset_count = reset_count + 1'b1;
        if (!reset_n_s) begin
          next_reset_count = '0;
        end else if (count_done) begin
          next_state = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (!reset_n_s) begin
          next_reset_count = '0;
          next_state = ST_RESETTING;
        end
      end
      default: begin
        next_state = ST_POWER_UP;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_POWER_UP;
      reset_count <= '0;
    end else begin
      state <= next_state;
      reset_count <= next_reset_count;
    end
  end

  // straps sampled the cycle the sequencer leaves reset
  wire strap_take = (state == ST_RESETTING) && (next_state == ST_RUNNING);

  wire reg_wr_basic = reg_write && !in_reset && (reg_addr == ADDR_BASIC);
  wire reg_wr_coding = reg_write && !in_reset && (reg_addr == ADDR_CODING);

  always_ff @(posedge clock) begin
    if (rst) begin
      basic_control_register <= REG_RESET;
      coding_control_register <= REG_RESET;
      led_strap_register <= REG_RESET;
    end else if (strap_take) begin
      led_strap_register[STRAP_SPEED_LOW_BIT] <= led_in_s[LED_SPEED_LOW];
      led_strap_register[STRAP_ACTIVITY_BIT] <= led_in_s[LED_ACTIVITY];
      led_strap_register[STRAP_LINK_BIT] <= led_in_s[LED_LINK];
      led_strap_register[STRAP_DUPLEX_BIT] <= led_in_s[LED_DUPLEX];
      led_strap_register[STRAP_SPEED_HIGH_BIT] <= led_in_s[LED_SPEED_HIGH];
      if (!autoneg_on) begin
        coding_control_register[CODING_BYPASS_BIT] <= strap_a_s;
        basic_control_register[CTRL_LOOPBACK_BIT] <= strap_b_s;
      end
    end else begin
      if (reg_wr_basic) begin
        basic_control_register <= reg_wdata;
      end
      if (reg_wr_coding) begin
        coding_control_register <= reg_wdata;
      end
    end
  end

  wire [15:0] read_mux =
    (reg_addr == ADDR_BASIC) ? basic_control_register :
    (reg_addr == ADDR_CODING) ? coding_control_register :
    (reg_addr == ADDR_STRAP) ? led_strap_register : 16'h0000;

  // power-down from pin or control bit
  wire next_power_down = power_down_s || basic_control_register[CTRL_POWER_DOWN_BIT];

  // LED pattern, active high drive
  wire [LED_COUNT-1:0] led_pattern;
  assign led_pattern[LED_SPEED_LOW] = link_good && !speed_100;
  assign led_pattern[LED_ACTIVITY] = activity && blink_slow;
  assign led_pattern[LED_LINK] = link_good && !(activity && blink_slow);
  assign led_pattern[LED_DUPLEX] = full_duplex ? 1'b1 : (collision && blink_fast);
  assign led_pattern[LED_SPEED_HIGH] = link_good && speed_100;

  // LED pins are inputs during reset so strap resistors are readable
  wire led_drive = !in_reset && !next_power_down;

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reset_done <= 1'b0;
      power_down <= 1'b0;
      tx_tristate <= 1'b1;
      mii_isolate <= 1'b1;
      led_out <= '0;
      led_oe <= '0;
      advert_select <= 2'b00;
      advert_valid <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? read_mux : 16'h0000;
      reset_done <= (next_state == ST_RUNNING);
      power_down <= next_power_down;
      tx_tristate <= next_power_down || in_reset;
      mii_isolate <= next_power_down || in_reset;
      led_out <= led_drive ? led_pattern : '0;
      led_oe <= led_drive ? '1 : '0;
      if (strap_take) begin
        advert_select <= {strap_b_s, strap_a_s};
      end
      advert_valid <= autoneg_on && !in_reset;
    end
  end

  // wave age since last flip; feeds the rate checks only
  localparam logic [CNT_W-1:0] SLOW_HALF = CNT_W'(SLOW_HALF_CYCLES);
  localparam logic [CNT_W-1:0] FAST_HALF = CNT_W'(FAST_HALF_CYCLES);
  localparam logic [CNT_W-1:0] AGE_START = CNT_W'(1'b1);
  logic slow_prev;
  logic fast_prev;
  logic [CNT_W-1:0] slow_age;
  logic [CNT_W-1:0] fast_age;
  wire slow_flip = (blink_slow != slow_prev);
  wire fast_flip = (blink_fast != fast_prev);

  always_ff @(posedge clock) begin
    if (rst) begin
      slow_prev <= 1'b0;
      fast_prev <= 1'b0;
      slow_age <= '0;
      fast_age <= '0;
    end else begin
      slow_prev <= blink_slow;
      fast_prev <= blink_fast;
      slow_age <= slow_flip ? AGE_START : slow_age + 1'b1;
      fast_age <= fast_flip ? AGE_START : fast_age + 1'b1;
    end
  end

  // reset_done only after a full count since power-up or pin release
  AST_DONE_AFTER_COUNT: assert property (@(posedge clock) disable iff (rst)
    $rose(reset_done) |-> $past(count_done)) else $error("reset_done rose early");
  AST_DONE_LOW_IN_RESET: assert property (@(posedge clock) disable iff (rst)
    (state == ST_RESETTING) && !count_done |=> !reset_done) else $error("reset_done high in reset");
  AST_PD_TRISTATE: assert property (@(posedge clock) disable iff (rst)
    power_down |-> (led_oe == '0) && tx_tristate && mii_isolate) else $error("drive in power-down");
  AST_PD_OR: assert property (@(posedge clock) disable iff (rst)
    power_down_s |=> power_down) else $error("power-down pin ignored");
  AST_OE_OFF_RESET: assert property (@(posedge clock) disable iff (rst)
    in_reset |=> led_oe == '0) else $error("LED driven during strap");
  AST_SPEED_LEDS: assert property (@(posedge clock) disable iff (rst)
    led_oe[LED_SPEED_LOW] |-> !(led_out[LED_SPEED_LOW] && led_out[LED_SPEED_HIGH]))
    else $error("both speed LEDs on");
  AST_FULL_DUPLEX_ON: assert property (@(posedge clock) disable iff (rst)
    full_duplex && led_drive |=> led_out[LED_DUPLEX]) else $error("duplex LED off");
  AST_STRAP_A: assert property (@(posedge clock) disable iff (rst)
    strap_take && !autoneg_on |=> coding_control_register[CODING_BYPASS_BIT] == $past(strap_a_s))
    else $error("coding bypass not strapped");
  AST_STRAP_B: assert property (@(posedge clock) disable iff (rst)
    strap_take && !autoneg_on |=> basic_control_register[CTRL_LOOPBACK_BIT] == $past(strap_b_s))
    else $error("loopback not strapped");
  AST_STRAP_LED: assert property (@(posedge clock) disable iff (rst)
    strap_take |=> led_strap_register[STRAP_SPEED_LOW_BIT] == $past(led_in_s[LED_SPEED_LOW]))
    else $error("LED strap not latched");

  // release: last count cycle, then done, then pins driven
  sequence seq_count_end;
    (state == ST_RESETTING) && count_done && reset_n_s;
  endsequence
  sequence seq_done_then_drive;
    reset_done ##1 ((led_oe == '1) || power_down);
  endsequence
  AST_RELEASE_ORDER: assert property (@(posedge clock) disable iff (rst)
    seq_count_end |=> seq_done_then_drive) else $error("release order wrong");
  AST_PD_BIT: assert property (@(posedge clock) disable iff (rst)
    basic_control_register[CTRL_POWER_DOWN_BIT] |=> power_down)
    else $error("power-down bit ignored");
  AST_SPEED_LOW_ON: assert property (@(posedge clock) disable iff (rst)
    link_good && !speed_100 && led_drive |=> led_out[LED_SPEED_LOW])
    else $error("10 Mb/s LED off");
  AST_SPEED_LOW_OFF: assert property (@(posedge clock) disable iff (rst)
    !(link_good && !speed_100) |=> !led_out[LED_SPEED_LOW]) else $error("10 Mb/s LED on");
  AST_SPEED_HIGH_ON: assert property (@(posedge clock) disable iff (rst)
    link_good && speed_100 && led_drive |=> led_out[LED_SPEED_HIGH])
    else $error("100 Mb/s LED off");
  AST_ACTIVITY_GATED: assert property (@(posedge clock) disable iff (rst)
    led_out[LED_ACTIVITY] |-> $past(activity)) else $error("activity LED without activity");
  AST_LINK_STEADY: assert property (@(posedge clock) disable iff (rst)
    link_good && !activity && led_drive |=> led_out[LED_LINK]) else $error("link LED off");
  AST_DUPLEX_QUIET: assert property (@(posedge clock) disable iff (rst)
    !full_duplex && !collision |=> !led_out[LED_DUPLEX]) else $error("duplex LED lit idle");
  AST_SLOW_RATE: assert property (@(posedge clock) disable iff (rst)
    slow_flip |-> slow_age == SLOW_HALF) else $error("activity blink rate wrong");
  AST_FAST_RATE: assert property (@(posedge clock) disable iff (rst)
    fast_flip |-> fast_age == FAST_HALF) else $error("collision blink rate wrong");
  AST_ADVERT_VALID: assert property (@(posedge clock) disable iff (rst)
    advert_valid |-> $past(autoneg_on)) else $error("advertisement without autoneg");
endmodule
`default_nettype wire

// >>> bench/led_strap_board.sv
`timescale 1ns/1ps
`default_nettype none
// board side of the LED pins: LED plus strap resistor on each pin
module led_strap_board (
  input wire logic [phy_aux_pkg::LED_COUNT-1:0] pull,
  input wire logic [phy_aux_pkg::LED_COUNT-1:0] led_out,
  input wire logic [phy_aux_pkg::LED_COUNT-1:0] led_oe,
  output logic [phy_aux_pkg::LED_COUNT-1:0] led_in
);
  import phy_aux_pkg::*;
  // a released pin settles to its strap resistor, never to the last drive
  assign led_in = (led_oe & led_out) | (~led_oe & pull);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
  import phy_aux_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reset_n_pin = 1'b1;
  logic power_down_pin = 1'b0;
  logic config_strap_a = 1'b1;
  logic config_strap_b = 1'b1;
  logic [LED_COUNT-1:0] pull = 5'h16;
  logic [LED_COUNT-1:0] led_in, led_out, led_oe;
  logic link_good = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0;
  logic activity = 1'b0, collision = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic reset_done, power_down, tx_tristate, mii_isolate, advert_valid;
  logic [1:0] advert_select;
  int miscompares = 0;
  int checks = 0;

  always #12.5 clock = ~clock;

  led_strap_board board_u (.pull(pull), .led_out(led_out), .led_oe(led_oe), .led_in(led_in));

  phy_led_strap_reset_ctrl dut_u (.clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
    .power_down_pin(power_down_pin), .config_strap_a(config_strap_a),
    .config_strap_b(config_strap_b), .led_in(led_in), .led_out(led_out), .led_oe(led_oe),
    .link_good(link_good), .speed_100(speed_100), .full_duplex(full_duplex),
    .activity(activity), .collision(collision), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reset_done(reset_done), .power_down(power_down), .tx_tristate(tx_tristate),
    .mii_isolate(mii_isolate), .advert_select(advert_select), .advert_valid(advert_valid));

  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // cycles from release until reset_done, counted without trusting the design
  task automatic wait_done;
    int n;
    n = 0;
    `CHK(reset_done, 1'b0)
    while (reset_done !== 1'b1 && n < 50000) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n > 40000 && n < 40020, 1'b1)
  endtask

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // three spans of just over 1 ms each, plus slack
  initial begin
    #3500000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    settle(1);
    `CHK(led_oe, 5'h00)
    `CHK({tx_tristate, mii_isolate}, 2'h3)
    wait_done();
    settle(1);
    `CHK(led_oe, 5'h1F)
    rdchk(4'h2, 16'h00B0);
    rdchk(4'h1, 16'h0002);
    rdchk(4'h0, 16'h4000);
    rdchk(4'h7, 16'h0000);
    wr(4'h2, 16'hFFFF);
    rdchk(4'h2, 16'h00B0);
    $display("test reset and straps done");
    @(posedge clock);
    link_good <= 1'b1;
    full_duplex <= 1'b1;
    settle(3);
    `CHK(led_out, 5'h16)
    `CHK(led_out[1], 1'b1)
    @(posedge clock);
    speed_100 <= 1'b1;
    full_duplex <= 1'b0;
    settle(3);
    `CHK(led_out, 5'h05)
    @(posedge clock);
    activity <= 1'b1;
    collision <= 1'b1;
    settle(3);
    // both blink waves start in their off half after reset
    `CHK(led_out, 5'h05)
    @(posedge clock);
    link_good <= 1'b0;
    activity <= 1'b0;
    collision <= 1'b0;
    settle(3);
    `CHK(led_out, 5'h00)
    $display("test steady leds done");
    @(posedge clock);
    power_down_pin <= 1'b1;
    settle(5);
    `CHK({power_down, tx_tristate, mii_isolate, led_oe}, 8'hE0)
    @(posedge clock);
    power_down_pin <= 1'b0;
    settle(5);
    `CHK({power_down, led_oe}, 6'h1F)
    wr(4'h0, 16'h0800);
    settle(2);
    `CHK({power_down, mii_isolate, led_oe}, 7'h60)
    wr(4'h0, 16'h1000);
    settle(2);
    `CHK({advert_valid, advert_select, power_down}, 4'hE)
    wr(4'h0, 16'h0000);
    settle(2);
    `CHK(advert_valid, 1'b0)
    $display("test power down and autoneg done");
    @(posedge clock);
    pull <= 5'h09;
    config_strap_a <= 1'b0;
    config_strap_b <= 1'b0;
    reset_n_pin <= 1'b0;
    settle(6);
    `CHK({reset_done, led_oe}, 6'h00)
    settle(RESET_CYCLES);
    @(posedge clock);
    reset_n_pin <= 1'b1;
    settle(1);
    wait_done();
    settle(1);
    rdchk(4'h2, 16'h0048);
    rdchk(4'h1, 16'h0000);
    rdchk(4'h0, 16'h0000);
    `CHK({advert_valid, advert_select}, 3'h0)
    $display("test pin reset done");
    conclude();
  end
endmodule
`default_nettype wire
